// File: core/timer3_pkg.sv
package timer3_pkg;
    // Register address
    localparam logic [7:0] CTRL_ADDR = 8'h91;
    localparam logic [3:0] CTRL_PAGE = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Field positions
    localparam int HIGH_FLAG_BIT = 7;
    localparam int LOW_FLAG_BIT = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int CAPTURE_EN_BIT = 4;
    localparam int SPLIT_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int CLKSEL_MSB = 1;
    localparam int CLKSEL_LSB = 0;
    // Clock select codes
    localparam logic [1:0] CLKSEL_DIV12_RTC = 2'h0;
    localparam logic [1:0] CLKSEL_EXT8_EXT8 = 2'h1;
    localparam logic [1:0] CLKSEL_RTC_EXT8 = 2'h3;
    // Alternate tick sources
    typedef enum logic [3:0] {
        SRC_DIV12 = 4'h1,
        SRC_EXT8 = 4'h2,
        SRC_RTC = 4'h4,
        SRC_NONE = 4'h8
    } tick_src_e;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage : timer3_pkg

// File: core/byte_counter.sv
`timescale 1ns/1ps
// One 8-bit counter stage with reload and wrap strobe
module byte_counter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic inc,
    input wire logic reload,
    input wire logic [7:0] reload_val,
    input wire logic wr_en,
    input wire logic [7:0] wr_val,
    // Status
    output logic [7:0] count_q,
    output logic wrap
);
    assign wrap = inc && (count_q == timer3_pkg::BYTE_MAX);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 8'h00;
        end else if (wr_en) begin
            count_q <= wr_val;
        end else if (reload) begin
            count_q <= reload_val;
        end else if (inc) begin
            count_q <= count_q + 8'h01;
        end
    end
endmodule : byte_counter

// File: core/timer3_control_status.sv
`timescale 1ns/1ps
module timer3_control_status (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Counter byte writes
    input wire logic count_low_wr,
    input wire logic count_high_wr,
    input wire logic reload_low_wr,
    input wire logic reload_high_wr,
    input wire logic [7:0] byte_wdata,
    // Tick sources: ext and rtc are synchronous one-cycle strobes, *_use_system_clock are level enables
    input wire logic ext_div8_tick,
    input wire logic rtc_tick,
    input wire logic high_use_system_clock,
    input wire logic low_use_system_clock,
    // Interrupt controller
    input wire logic timer_irq_enable,
    output logic irq_req,
    // Counter state
    output logic [7:0] count_low_byte,
    output logic [7:0] count_high_byte,
    output logic [7:0] reload_low_byte,
    output logic [7:0] reload_high_byte
);
    logic [7:0] ctrl_q;
    logic [3:0] div12_q;
    logic [7:0] reload_low_q, reload_high_q;
    logic div12_tick, alt_tick, capture_evt;
    logic high_flag_set, low_flag_set;
    logic low_inc, high_inc, low_wrap, high_wrap;
    logic split, run, cap_en, low_irq_en, reload16;
    logic ctrl_sel;
    timer3_pkg::tick_src_e alt_src, cap_src;

    function automatic timer3_pkg::tick_src_e alt_of(input logic [1:0] s);
        case (s)
            timer3_pkg::CLKSEL_DIV12_RTC: alt_of = timer3_pkg::SRC_DIV12;
            timer3_pkg::CLKSEL_EXT8_EXT8: alt_of = timer3_pkg::SRC_EXT8;
            timer3_pkg::CLKSEL_RTC_EXT8: alt_of = timer3_pkg::SRC_RTC;
            default: alt_of = timer3_pkg::SRC_NONE;
        endcase
    endfunction : alt_of

    function automatic timer3_pkg::tick_src_e cap_of(input logic [1:0] s);
        case (s)
            timer3_pkg::CLKSEL_DIV12_RTC: cap_of = timer3_pkg::SRC_RTC;
            timer3_pkg::CLKSEL_EXT8_EXT8: cap_of = timer3_pkg::SRC_EXT8;
            timer3_pkg::CLKSEL_RTC_EXT8: cap_of = timer3_pkg::SRC_EXT8;
            default: cap_of = timer3_pkg::SRC_NONE;
        endcase
    endfunction : cap_of

    function automatic logic pick(input timer3_pkg::tick_src_e src,
                                  input logic d12, input logic e8,
                                  input logic rt);
        case (src)
            timer3_pkg::SRC_DIV12: pick = d12;
            timer3_pkg::SRC_EXT8: pick = e8;
            timer3_pkg::SRC_RTC: pick = rt;
            default: pick = 1'b0;
        endcase
    endfunction : pick

    // Field views
    assign split = ctrl_q[timer3_pkg::SPLIT_BIT];
    assign run = ctrl_q[timer3_pkg::RUN_BIT];
    assign cap_en = ctrl_q[timer3_pkg::CAPTURE_EN_BIT];
    assign low_irq_en = ctrl_q[timer3_pkg::LOW_IRQ_EN_BIT];
    assign ctrl_sel = sfr_wr && (sfr_addr == timer3_pkg::CTRL_ADDR)
        && (sfr_page == timer3_pkg::CTRL_PAGE);

    // System clock divided by twelve
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div12_q <= 4'h0;
        end else if (div12_q == timer3_pkg::DIV12_LAST) begin
            div12_q <= 4'h0;
        end else begin
            div12_q <= div12_q + 4'h1;
        end
    end
    assign div12_tick = (div12_q == timer3_pkg::DIV12_LAST);

    // Tick and capture trigger selection
    assign alt_src = alt_of(ctrl_q[timer3_pkg::CLKSEL_MSB:
                                   timer3_pkg::CLKSEL_LSB]);
    assign cap_src = cap_of(ctrl_q[timer3_pkg::CLKSEL_MSB:
                                   timer3_pkg::CLKSEL_LSB]);
    assign alt_tick = pick(alt_src, div12_tick, ext_div8_tick, rtc_tick);
    assign capture_evt = cap_en && pick(cap_src, div12_tick,
                                        ext_div8_tick, rtc_tick);

    // Counter increments
    always_comb begin
        low_inc = 1'b0;
        high_inc = 1'b0;
        if (split) begin
            low_inc = low_use_system_clock | alt_tick;
            high_inc = run && (high_use_system_clock | alt_tick);
        end else begin
            low_inc = run && (low_use_system_clock | alt_tick);
            high_inc = low_inc && (count_low_byte == timer3_pkg::BYTE_MAX);
        end
    end
    assign reload16 = !split && high_wrap;

    byte_counter u_low (
        .core_clk(core_clk),
        .resetn(resetn),
        .inc(low_inc),
        .reload(split ? low_wrap : reload16),
        .reload_val(reload_low_q),
        .wr_en(count_low_wr),
        .wr_val(byte_wdata),
        .count_q(count_low_byte),
        .wrap(low_wrap)
    );

    byte_counter u_high (
        .core_clk(core_clk),
        .resetn(resetn),
        .inc(high_inc),
        .reload(high_wrap),
        .reload_val(reload_high_q),
        .wr_en(count_high_wr),
        .wr_val(byte_wdata),
        .count_q(count_high_byte),
        .wrap(high_wrap)
    );

    // Reload registers, capture copies count in
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reload_low_q <= 8'h00;
            reload_high_q <= 8'h00;
        end else if (capture_evt) begin
            reload_low_q <= count_low_byte;
            reload_high_q <= count_high_byte;
        end else begin
            if (reload_low_wr) begin
                reload_low_q <= byte_wdata;
            end
            if (reload_high_wr) begin
                reload_high_q <= byte_wdata;
            end
        end
    end
    assign reload_low_byte = reload_low_q;
    assign reload_high_byte = reload_high_q;

    // Flag set events
    assign high_flag_set = high_wrap || capture_evt;
    assign low_flag_set = low_wrap;

    // Control register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= timer3_pkg::CTRL_RESET;
        end else begin
            if (ctrl_sel) begin
                ctrl_q <= sfr_wdata;
            end
            // Hardware only sets; set wins over write
            if (high_flag_set) begin
                ctrl_q[timer3_pkg::HIGH_FLAG_BIT] <= 1'b1;
            end
            if (low_flag_set) begin
                ctrl_q[timer3_pkg::LOW_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_addr == timer3_pkg::CTRL_ADDR
                     && sfr_page == timer3_pkg::CTRL_PAGE) begin
            sfr_rdata <= ctrl_q;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Interrupt request level
    assign irq_req = timer_irq_enable
        && (ctrl_q[timer3_pkg::HIGH_FLAG_BIT]
            || (low_irq_en && ctrl_q[timer3_pkg::LOW_FLAG_BIT]));

    // Checks
    chk_high_flag_set: assert property (@(posedge core_clk)
        disable iff (!resetn)
        high_flag_set |=> ctrl_q[timer3_pkg::HIGH_FLAG_BIT])
        else $error("high flag not set");
    chk_irq_follows: assert property (@(posedge core_clk)
        disable iff (!resetn)
        high_flag_set |=> (irq_req == timer_irq_enable))
        else $error("irq does not follow high flag");
    chk_no_hw_clear: assert property (@(posedge core_clk)
        disable iff (!resetn)
        ($past(ctrl_q[timer3_pkg::HIGH_FLAG_BIT])
        && !ctrl_q[timer3_pkg::HIGH_FLAG_BIT]) |-> $past(ctrl_sel))
        else $error("high flag cleared by hardware");
    chk_low_flag_set: assert property (@(posedge core_clk)
        disable iff (!resetn)
        low_wrap |=> ctrl_q[timer3_pkg::LOW_FLAG_BIT])
        else $error("low flag not set");
    chk_low_irq: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (low_wrap && low_irq_en && !ctrl_sel)
        |=> (irq_req == timer_irq_enable))
        else $error("irq does not follow low overflow");
    chk_capture_copy: assert property (@(posedge core_clk)
        disable iff (!resetn)
        capture_evt |=> (reload_low_q == $past(count_low_byte)
        && reload_high_q == $past(count_high_byte)))
        else $error("capture did not copy");
    chk_split_low_runs: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (split && low_use_system_clock && !count_low_wr)
        |=> (count_low_byte == $past(count_low_byte) + 8'h01
        || $past(low_wrap)))
        else $error("split low byte stalled");
    chk_wrap16_reload: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (reload16 && !count_low_wr && !count_high_wr)
        |=> (count_low_byte == $past(reload_low_q)
        && count_high_byte == $past(reload_high_q)))
        else $error("16-bit reload missed");
endmodule : timer3_control_status

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, byte_wdata = 8'h00;
    logic [3:0] sfr_page = 4'h0;
    logic sfr_wr = 1'b0, count_low_wr = 1'b0, count_high_wr = 1'b0;
    logic reload_low_wr = 1'b0, reload_high_wr = 1'b0;
    logic ext_div8_tick = 1'b0, rtc_tick = 1'b0, high_use_system_clock = 1'b0;
    logic low_use_system_clock = 1'b0, timer_irq_enable = 1'b0;
    logic irq_req;
    logic [7:0] sfr_rdata, count_low_byte, count_high_byte;
    logic [7:0] reload_low_byte, reload_high_byte, v;
    int num_errors = 0, samples_checked = 0;
    logic [1:0] sel_tab [3] = '{2'h0, 2'h1, 2'h3};
    logic [1:0] tick_tab [3] = '{2'h2, 2'h1, 2'h1};

    always #4 core_clk = ~core_clk;

    timer3_control_status dut_u (.core_clk(core_clk), .resetn(resetn),
        .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .count_low_wr(count_low_wr), .count_high_wr(count_high_wr),
        .reload_low_wr(reload_low_wr), .reload_high_wr(reload_high_wr),
        .byte_wdata(byte_wdata), .ext_div8_tick(ext_div8_tick),
        .rtc_tick(rtc_tick), .high_use_system_clock(high_use_system_clock),
        .low_use_system_clock(low_use_system_clock), .timer_irq_enable(timer_irq_enable),
        .irq_req(irq_req), .count_low_byte(count_low_byte),
        .count_high_byte(count_high_byte), .reload_low_byte(reload_low_byte),
        .reload_high_byte(reload_high_byte));

    task automatic final_report();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] d);
        sfr_addr = timer3_pkg::CTRL_ADDR;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        tick(1);
        d = sfr_rdata;
    endtask : rd

    task automatic bw(input logic [3:0] sel, input logic [7:0] d);
        {reload_high_wr, reload_low_wr, count_high_wr, count_low_wr} = sel;
        byte_wdata = d;
        tick(1);
        {reload_high_wr, reload_low_wr, count_high_wr, count_low_wr} = 4'h0;
        tick(1);
    endtask : bw

    task automatic pulse(input logic [1:0] s);
        {rtc_tick, ext_div8_tick} = s;
        tick(1);
        {rtc_tick, ext_div8_tick} = 2'h0;
        tick(1);
    endtask : pulse

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq_req !== 1'b1; i++) tick(1);
        if (irq_req !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask : wait_irq

    initial begin
        tick(8);
        resetn = 1'b1;
        rd(8'h91, v);
        check(v, 8'h00);
        wr(8'hAB);
        rd(8'h91, v);
        check(v, 8'hAB);
        sfr_page = 4'h1;
        wr(8'hFF);
        rd(8'h91, v);
        check(v, 8'h00);
        sfr_page = 4'h0;
        rd(8'h91, v);
        check(v, 8'hAB);
        rd(8'h92, v);
        check(v, 8'h00);
        wr(8'h00);
        rd(8'h91, v);
        check(v, 8'h00);
        // 16-bit wrap with reload
        bw(4'h1, 8'hFE);
        bw(4'h2, 8'hFF);
        bw(4'h4, 8'h12);
        bw(4'h8, 8'h34);
        timer_irq_enable = 1'b1;
        low_use_system_clock = 1'b1;
        wr(8'h04);
        wait_irq(10);
        wr(8'hC0);
        rd(8'h91, v);
        check(v, 8'hC0);
        check(count_high_byte, 8'h34);
        check(count_low_byte, 8'h13);
        tick(20);
        rd(8'h91, v);
        check(v, 8'hC0);
        wr(8'h00);
        rd(8'h91, v);
        check(v, 8'h00);
        check({7'h00, irq_req}, 8'h00);
        // Split mode, low byte free-running, upper stopped
        bw(4'h1, 8'hFD);
        high_use_system_clock = 1'b1;
        wr(8'h28);
        wait_irq(10);
        rd(8'h91, v);
        check(v, 8'h68);
        check(count_high_byte, 8'h34);
        wr(8'h48);
        tick(1);
        check({7'h00, irq_req}, 8'h00);
        low_use_system_clock = 1'b0;
        high_use_system_clock = 1'b0;
        wr(8'h00);
        // Capture on each trigger source, other source ignored
        for (int i = 0; i < 3; i++) begin
            bw(4'h1, 8'h56 + 8'(i));
            bw(4'h2, 8'h78);
            wr(8'h10 | {6'h00, sel_tab[i]});
            pulse(tick_tab[i]);
            bw(4'h1, 8'hEE);
            pulse(~tick_tab[i]);
            tick(2);
            check(reload_low_byte, 8'h56 + 8'(i));
            check(reload_high_byte, 8'h78);
            rd(8'h91, v);
            check(v, 8'h90 | {6'h00, sel_tab[i]});
            wr(8'h00);
        end
        bw(4'h1, 8'h11);
        pulse(2'h2);
        tick(2);
        check(reload_low_byte, 8'h58);
        // Alternate tick from external source
        bw(4'h1, 8'h00);
        wr(8'h05);
        pulse(2'h1);
        pulse(2'h1);
        pulse(2'h1);
        pulse(2'h2);
        tick(2);
        check(count_low_byte, 8'h03);
        wr(8'h01);
        pulse(2'h1);
        tick(2);
        check(count_low_byte, 8'h03);
        final_report();
    end
endmodule : tb_top
